// [rtl/bal_pkg.sv]
// Constants and types for the byte arithmetic and logic datapath
package bal_pkg;
    // APB byte addresses of the registers
    localparam logic [7:0] OFF_GPR_LAST = 8'h1C;
    localparam logic [7:0] OFF_FLAGS    = 8'h20;
    localparam logic [7:0] OFF_SP       = 8'h24;
    localparam logic [7:0] OFF_IMM      = 8'h28;
    localparam logic [7:0] OFF_CMD      = 8'h2C;
    localparam logic [7:0] OFF_STATUS   = 8'h30;

    // Register select codes; slot 6 is the memory byte at the pointer pair
    localparam logic [2:0] SEL_H = 3'h4;
    localparam logic [2:0] SEL_L = 3'h5;
    localparam logic [2:0] SEL_M = 3'h6;
    localparam logic [2:0] SEL_A = 3'h7;

    // Register pair select codes
    localparam logic [1:0] PAIR_BC = 2'h0;
    localparam logic [1:0] PAIR_DE = 2'h1;
    localparam logic [1:0] PAIR_HL = 2'h2;

    // Flag bit positions
    localparam int FLG_S  = 7;
    localparam int FLG_Z  = 6;
    localparam int FLG_AC = 4;
    localparam int FLG_P  = 2;
    localparam int FLG_CY = 0;

    // Command register fields
    localparam int CMD_OP_LSB   = 0;
    localparam int CMD_SEL_LSB  = 4;
    localparam int CMD_PAIR_LSB = 8;

    // Status register fields
    localparam int STAT_BUSY       = 0;
    localparam int STAT_CYCLES_LSB = 4;
    localparam int STAT_STATES_LSB = 8;

    // Reset values
    localparam logic [7:0]  RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;

    // Machine cycle and state counts
    localparam logic [3:0] CYC_1 = 4'h1;
    localparam logic [3:0] CYC_2 = 4'h2;
    localparam logic [3:0] CYC_3 = 4'h3;
    localparam logic [3:0] ST_4  = 4'h4;
    localparam logic [3:0] ST_5  = 4'h5;
    localparam logic [3:0] ST_7  = 4'h7;
    localparam logic [3:0] ST_10 = 4'hA;

    // Decimal adjust limits
    localparam logic [3:0] BCD_MAX = 4'h9;
    localparam logic [3:0] BCD_ADJ = 4'h6;

    // Operations
    typedef enum logic [3:0] {
        OP_SUB_WITH_BORROW      = 4'b0000,
        OP_SUB_IMMEDIATE_BORROW = 4'b0001,
        OP_INCR_BYTE            = 4'b0010,
        OP_DECR_BYTE            = 4'b0011,
        OP_INCR_PAIR            = 4'b0100,
        OP_DECR_PAIR            = 4'b0101,
        OP_DOUBLE_ADD           = 4'b0110,
        OP_DECIMAL_ADJUST       = 4'b0111,
        OP_AND_OPERAND          = 4'b1000,
        OP_AND_IMMEDIATE        = 4'b1001,
        OP_XOR_OPERAND          = 4'b1010,
        OP_XOR_IMMEDIATE        = 4'b1011,
        OP_OR_OPERAND           = 4'b1100,
        OP_OR_IMMEDIATE         = 4'b1101,
        OP_COMPARE_OPERAND      = 4'b1110
    } bal_op_t;
    localparam logic [3:0] OP_ILLEGAL = 4'b1111;
endpackage

// [rtl/bal_alu.sv]
// Byte arithmetic and logic datapath with APB register access
//
// Function
// RQ1: Register subtract with borrow: A minus register minus carry into A.
// RQ2: Memory subtract with borrow: A minus byte at pointer minus carry.
// RQ3: Immediate subtract with borrow uses second byte; 2 cycles, 7 states.
// RQ4: Register increment in 1 cycle, 5 states; carry kept.
// RQ5: Memory increment read-modify-write, 3 cycles, 10 states; carry kept.
// RQ6: Register decrement updates all flags but carry.
// RQ7: Memory decrement, 3 cycles, 10 states; only Z, S, P, AC change.
// RQ8: Pair increment in 1 cycle, 5 states; no flag changes.
// RQ9: Pair decrement as sixteen bits; no flag changes.
// RQ10: Double add pair into pointer pair; carry from bit 15 only.
// RQ11: Decimal adjust adds 6 if low nibble above 9 or AC set.
// RQ12: Then adds 6 to high nibble if above 9 or carry; all flags.
// RQ13: Logic ops update Z, S, P, AC, carry by standard rules.
// RQ14: AND clears carry; register form 1 cycle, 4 states.
// RQ15: Immediate AND clears carry and AC; 2 cycles, 7 states.
// RQ16: XOR clears carry and AC; register form 4 states.
// RQ17: Immediate XOR clears carry and AC; 2 cycles, 7 states.
// RQ18: OR clears carry and AC; memory form 2 cycles, 7 states.
// RQ19: Compare sets flags only, accumulator kept; 1 cycle, 4 states. The memory form here takes 2 cycles, 7 states.
// RQ20: Compare sets Z when equal, carry when A below operand.
// RQ21: Subtraction is two's complement; carry means borrow.
// RQ22: Z for zero, S is bit 7, P even ones, AC from bit 3.
//
// The APB interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
module bal_alu
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Memory address from the pointer pair
    output logic      [15:0] mem_addr
);

    // Register file: B C D E H L, memory byte, accumulator
    logic [7:0]       gpr [0:7];
    logic [7:0]       flags;
    logic [15:0]      sp;
    logic [7:0]       imm;
    // Command execution state
    bal_pkg::bal_op_t op_q;
    logic [2:0]       sel_q;
    logic [1:0]       pair_q;
    logic             busy;
    logic [3:0]       cnt;
    logic [3:0]       last_cycles;
    logic [3:0]       last_states;
    // APB state
    logic             err_q;
    logic [31:0]      next_prdata;
    logic             next_err;
    logic             wr;
    logic             start;
    logic             commit;
    // Datapath results
    logic [7:0]       res8;
    logic [2:0]       dst8;
    logic             wr8;
    logic [15:0]      res16;
    logic             wr16;
    logic [7:0]       next_flags;
    // Top bit of the command op field
    localparam int CMD_OP_MSB = bal_pkg::CMD_OP_LSB + 3;
    // Timing of the command being written, pair value for the checks
    logic [7:0]       start_timing;
    logic [15:0]      pv_chk;

    // Timing of each operation: cycles in upper nibble, states in lower
    function automatic logic [7:0] op_timing(input logic [3:0] op,
                                             input logic [2:0] sel);
        logic mem;
        mem = (sel == bal_pkg::SEL_M);
        op_timing = {bal_pkg::CYC_2, bal_pkg::ST_7};
        case (op)
            bal_pkg::OP_SUB_WITH_BORROW, bal_pkg::OP_AND_OPERAND,
            bal_pkg::OP_XOR_OPERAND, bal_pkg::OP_OR_OPERAND,
            bal_pkg::OP_COMPARE_OPERAND:
                op_timing = mem ? {bal_pkg::CYC_2, bal_pkg::ST_7}
                                : {bal_pkg::CYC_1, bal_pkg::ST_4}; // RQ14
            bal_pkg::OP_INCR_BYTE, bal_pkg::OP_DECR_BYTE:
                op_timing = mem ? {bal_pkg::CYC_3, bal_pkg::ST_10}
                                : {bal_pkg::CYC_1, bal_pkg::ST_5}; // RQ5
            bal_pkg::OP_INCR_PAIR, bal_pkg::OP_DECR_PAIR:
                op_timing = {bal_pkg::CYC_1, bal_pkg::ST_5}; // RQ8
            bal_pkg::OP_DOUBLE_ADD:
                op_timing = {bal_pkg::CYC_3, bal_pkg::ST_10};
            bal_pkg::OP_DECIMAL_ADJUST:
                op_timing = {bal_pkg::CYC_1, bal_pkg::ST_4};
            default:
                op_timing = {bal_pkg::CYC_2, bal_pkg::ST_7}; // RQ3
        endcase
    endfunction

    // Zero, sign and parity of a result byte in flag layout
    function automatic logic [7:0] szp(input logic [7:0] r);
        szp = 8'h00;
        szp[bal_pkg::FLG_S] = r[7]; // RQ22
        szp[bal_pkg::FLG_Z] = (r == 8'h00);
        szp[bal_pkg::FLG_P] = ~^r;
    endfunction

    // Sixteen-bit value of a register pair
    function automatic logic [15:0] pair_value(input logic [1:0] p,
                                               input logic [7:0] hi_b,
                                               input logic [7:0] lo_b,
                                               input logic [15:0] s);
        pair_value = (p == 2'h3) ? s : {hi_b, lo_b};
    endfunction

    // APB: zero wait states, answer prepared in the setup cycle
    assign pready   = 1'b1;
    assign pslverr  = err_q;
    assign wr       = psel && penable && pwrite && !err_q;
    assign start    = wr && (paddr == bal_pkg::OFF_CMD);
    assign commit   = busy && (cnt == 4'h0);
    assign mem_addr = {gpr[bal_pkg::SEL_H], gpr[bal_pkg::SEL_L]};

    // Read mux and refusal decode; writes are refused while busy so the
    // datapath operands stay frozen during a command
    always_comb
    begin
        next_prdata = 32'h0000_0000;
        next_err    = 1'b0;
        if (paddr <= bal_pkg::OFF_GPR_LAST && paddr[1:0] == 2'h0)
        begin
            next_prdata = {24'h00_0000, gpr[paddr[4:2]]};
            next_err    = pwrite && busy;
        end
        else
        begin
            unique case (paddr)
                bal_pkg::OFF_FLAGS:
                begin
                    next_prdata = {24'h00_0000, flags};
                    next_err    = pwrite && busy;
                end
                bal_pkg::OFF_SP:
                begin
                    next_prdata = {16'h0000, sp};
                    next_err    = pwrite && busy;
                end
                bal_pkg::OFF_IMM:
                begin
                    next_prdata = {24'h00_0000, imm};
                    next_err    = pwrite && busy;
                end
                bal_pkg::OFF_CMD:
                begin
                    next_prdata = {22'h00_0000, pair_q, 1'b0, sel_q,
                                   op_q};
                    next_err    = pwrite && (busy ||
                        pwdata[CMD_OP_MSB:bal_pkg::CMD_OP_LSB]
                        == bal_pkg::OP_ILLEGAL);
                end
                bal_pkg::OFF_STATUS:
                begin
                    next_prdata = {20'h0_0000, last_states, last_cycles,
                                   3'h0, busy};
                    next_err    = pwrite;
                end
                default:
                begin
                    next_prdata = 32'h0000_0000;
                    next_err    = 1'b1;
                end
            endcase
        end
    end

    // Timing looked up once from the write data of the command
    assign start_timing = op_timing(pwdata[CMD_OP_MSB:bal_pkg::CMD_OP_LSB],
                                    pwdata[bal_pkg::CMD_SEL_LSB +: 3]);

    // Read data and error captured in the setup phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h0000_0000;
            err_q  <= 1'b0;
        end
        else if (psel && !penable)
        begin
            prdata <= next_prdata;
            err_q  <= next_err;
        end
    end

    // Command sequencer: one pclk per state, results land on last state
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            busy        <= 1'b0;
            cnt         <= 4'h0;
            op_q        <= bal_pkg::OP_SUB_WITH_BORROW;
            sel_q       <= 3'h0;
            pair_q      <= 2'h0;
            last_cycles <= 4'h0;
            last_states <= 4'h0;
        end
        else if (start)
        begin
            busy   <= 1'b1;
            op_q   <= bal_pkg::bal_op_t'(
                          pwdata[CMD_OP_MSB:bal_pkg::CMD_OP_LSB]);
            sel_q  <= pwdata[bal_pkg::CMD_SEL_LSB +: 3];
            pair_q <= pwdata[bal_pkg::CMD_PAIR_LSB +: 2];
            {last_cycles, last_states} <= start_timing;
            cnt    <= start_timing[3:0] - 4'h1;
        end
        else if (busy)
        begin
            busy <= (cnt != 4'h0);
            cnt  <= (cnt == 4'h0) ? 4'h0 : cnt - 4'h1;
        end
    end

    // Datapath for the latched command
    always_comb
    begin
        logic [7:0]  acc;
        logic [7:0]  opnd;
        logic        cy;
        logic        ac;
        logic        cyin;
        logic [8:0]  diff;
        logic [4:0]  nib;
        logic [15:0] pv;
        logic [15:0] hl;
        logic [16:0] sum;
        logic        lo_adj;
        logic        hi_adj;
        logic [8:0]  t1;
        logic [8:0]  t2;
        logic [4:0]  lo5;
        acc    = gpr[bal_pkg::SEL_A];
        cy     = flags[bal_pkg::FLG_CY];
        ac     = flags[bal_pkg::FLG_AC];
        opnd   = gpr[sel_q];
        cyin   = 1'b0;
        diff   = 9'h000;
        nib    = 5'h00;
        pv     = pair_value(pair_q, gpr[{pair_q, 1'b0}],
                            gpr[{pair_q, 1'b1}], sp);
        hl     = {gpr[bal_pkg::SEL_H], gpr[bal_pkg::SEL_L]};
        sum    = 17'h0_0000;
        lo_adj = 1'b0;
        hi_adj = 1'b0;
        t1     = 9'h000;
        t2     = 9'h000;
        lo5    = 5'h00;
        res8   = 8'h00;
        dst8   = bal_pkg::SEL_A;
        wr8    = 1'b0;
        res16  = 16'h0000;
        wr16   = 1'b0;
        next_flags = flags;
        if (op_q == bal_pkg::OP_SUB_IMMEDIATE_BORROW ||
            op_q == bal_pkg::OP_AND_IMMEDIATE ||
            op_q == bal_pkg::OP_XOR_IMMEDIATE ||
            op_q == bal_pkg::OP_OR_IMMEDIATE)
            opnd = imm; // RQ3
        unique case (op_q)
            bal_pkg::OP_SUB_WITH_BORROW, bal_pkg::OP_SUB_IMMEDIATE_BORROW,
            bal_pkg::OP_COMPARE_OPERAND:
            begin
                // Two's complement subtract; carry out inverted is borrow
                cyin = (op_q == bal_pkg::OP_COMPARE_OPERAND) ? 1'b0 : cy;
                diff = {1'b0, acc} - {1'b0, opnd} - {8'h00, cyin}; // RQ21
                nib  = {1'b0, acc[3:0]} + {1'b0, ~opnd[3:0]}
                       + {4'h0, ~cyin};
                res8 = diff[7:0]; // RQ1 RQ2
                wr8  = (op_q != bal_pkg::OP_COMPARE_OPERAND); // RQ19
                next_flags = szp(diff[7:0]);
                next_flags[bal_pkg::FLG_AC] = nib[4]; // RQ22
                next_flags[bal_pkg::FLG_CY] = diff[8]; // RQ20
            end
            bal_pkg::OP_INCR_BYTE, bal_pkg::OP_DECR_BYTE:
            begin
                // Carry is kept from before
                dst8 = sel_q;
                wr8  = 1'b1;
                if (op_q == bal_pkg::OP_INCR_BYTE)
                    res8 = opnd + 8'h01; // RQ4
                else
                    res8 = opnd - 8'h01; // RQ6
                next_flags = szp(res8);
                next_flags[bal_pkg::FLG_AC] =
                    (op_q == bal_pkg::OP_INCR_BYTE) ?
                    (opnd[3:0] == 4'hF) : (opnd[3:0] != 4'h0); // RQ7
                next_flags[bal_pkg::FLG_CY] = cy; // RQ4 RQ6 RQ7
            end
            bal_pkg::OP_INCR_PAIR, bal_pkg::OP_DECR_PAIR:
            begin
                wr16  = 1'b1;
                res16 = (op_q == bal_pkg::OP_INCR_PAIR) ?
                        pv + 16'h0001 : pv - 16'h0001; // RQ8 RQ9
            end
            bal_pkg::OP_DOUBLE_ADD:
            begin
                sum   = {1'b0, hl} + {1'b0, pv};
                res16 = sum[15:0]; // RQ10
                next_flags[bal_pkg::FLG_CY] = sum[16]; // RQ10
            end
            bal_pkg::OP_DECIMAL_ADJUST:
            begin
                // Both steps in one pass; the high test sees step one
                lo_adj = ac || (acc[3:0] > bal_pkg::BCD_MAX); // RQ11
                lo5    = {1'b0, acc[3:0]} + {1'b0, bal_pkg::BCD_ADJ};
                t1     = {1'b0, acc} +
                         (lo_adj ? {5'h00, bal_pkg::BCD_ADJ} : 9'h000);
                hi_adj = cy || t1[8] || (t1[7:4] > bal_pkg::BCD_MAX);
                t2     = {1'b0, t1[7:0]} +
                         (hi_adj ? {1'b0, bal_pkg::BCD_ADJ, 4'h0}
                                 : 9'h000); // RQ12
                res8   = t2[7:0];
                wr8    = 1'b1;
                next_flags = szp(t2[7:0]);
                next_flags[bal_pkg::FLG_AC] = lo_adj && lo5[4];
                next_flags[bal_pkg::FLG_CY] = cy || t1[8] || t2[8];
            end
            bal_pkg::OP_AND_OPERAND, bal_pkg::OP_AND_IMMEDIATE:
            begin
                res8 = acc & opnd;
                wr8  = 1'b1;
                next_flags = szp(res8); // RQ13
                next_flags[bal_pkg::FLG_AC] =
                    (op_q == bal_pkg::OP_AND_OPERAND) &&
                    (acc[3] || opnd[3]); // RQ15
                next_flags[bal_pkg::FLG_CY] = 1'b0; // RQ14
            end
            bal_pkg::OP_XOR_OPERAND, bal_pkg::OP_XOR_IMMEDIATE,
            bal_pkg::OP_OR_OPERAND, bal_pkg::OP_OR_IMMEDIATE:
            begin
                res8 = (op_q == bal_pkg::OP_XOR_OPERAND ||
                        op_q == bal_pkg::OP_XOR_IMMEDIATE) ?
                       (acc ^ opnd) : (acc | opnd); // RQ16 RQ18
                wr8  = 1'b1;
                next_flags = szp(res8); // RQ17
            end
            default:
            begin
                wr8 = 1'b0;
            end
        endcase
    end

    // Byte registers: software writes when idle, results at commit
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < 8; i++)
                gpr[i] <= bal_pkg::RST_BYTE;
        end
        else if (wr && paddr <= bal_pkg::OFF_GPR_LAST)
            gpr[paddr[4:2]] <= pwdata[7:0];
        else if (commit && wr8)
            gpr[dst8] <= res8; // RQ5
        else if (commit && (wr16 || op_q == bal_pkg::OP_DOUBLE_ADD))
        begin
            if (op_q == bal_pkg::OP_DOUBLE_ADD)
            begin
                gpr[bal_pkg::SEL_H] <= res16[15:8]; // RQ10
                gpr[bal_pkg::SEL_L] <= res16[7:0];
            end
            else if (pair_q != 2'h3)
            begin
                gpr[{pair_q, 1'b0}] <= res16[15:8];
                gpr[{pair_q, 1'b1}] <= res16[7:0];
            end
        end
    end

    // Stack pointer, reached only as pair 3
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            sp <= bal_pkg::RST_WORD;
        else if (wr && paddr == bal_pkg::OFF_SP)
            sp <= pwdata[15:0];
        else if (commit && wr16 && pair_q == 2'h3)
            sp <= res16; // RQ9
    end

    // Flags and immediate byte
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            flags <= bal_pkg::RST_BYTE;
            imm   <= bal_pkg::RST_BYTE;
        end
        else
        begin
            if (wr && paddr == bal_pkg::OFF_FLAGS)
                flags <= pwdata[7:0] & 8'hD5;
            else if (commit)
                flags <= next_flags; // RQ13
            if (wr && paddr == bal_pkg::OFF_IMM)
                imm <= pwdata[7:0];
        end
    end

    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_start_sbi;
        start && pwdata[3:0] == bal_pkg::OP_SUB_IMMEDIATE_BORROW;
    endsequence
    sequence s_start_incr_mem;
        start && pwdata[3:0] == bal_pkg::OP_INCR_BYTE &&
        pwdata[6:4] == bal_pkg::SEL_M;
    endsequence

    property p_sbi_seven;
        s_start_sbi |=> busy [*7] ##1 !busy;
    endproperty
    a_sbi_seven: assert property (p_sbi_seven) // RQ3
        else $error("immediate subtract not seven states");

    property p_incr_mem_ten;
        s_start_incr_mem |=> busy [*8] ##1 busy [*2] ##1 !busy;
    endproperty
    a_incr_mem_ten: assert property (p_incr_mem_ten) // RQ5
        else $error("memory increment not ten states");

    property p_cmp_keeps_acc;
        commit && op_q == bal_pkg::OP_COMPARE_OPERAND
        |=> $stable(gpr[bal_pkg::SEL_A]);
    endproperty
    a_cmp_keeps_acc: assert property (p_cmp_keeps_acc) // RQ19
        else $error("compare changed accumulator");

    property p_cmp_flags;
        commit && op_q == bal_pkg::OP_COMPARE_OPERAND
        |=> flags[bal_pkg::FLG_Z] == ($past(gpr[bal_pkg::SEL_A]) ==
                                      $past(gpr[sel_q])) &&
            flags[bal_pkg::FLG_CY] == ($past(gpr[bal_pkg::SEL_A]) <
                                       $past(gpr[sel_q]));
    endproperty
    a_cmp_flags: assert property (p_cmp_flags) // RQ20
        else $error("compare flags wrong");

    property p_incdec_keep_cy;
        commit && (op_q == bal_pkg::OP_INCR_BYTE ||
                   op_q == bal_pkg::OP_DECR_BYTE)
        |=> $stable(flags[bal_pkg::FLG_CY]);
    endproperty
    a_incdec_keep_cy: assert property (p_incdec_keep_cy) // RQ6
        else $error("byte step changed carry");

    property p_pair_no_flags;
        commit && (op_q == bal_pkg::OP_INCR_PAIR ||
                   op_q == bal_pkg::OP_DECR_PAIR) |=> $stable(flags);
    endproperty
    a_pair_no_flags: assert property (p_pair_no_flags) // RQ8
        else $error("pair step changed flags");

    property p_logic_clears_cy;
        commit && op_q >= bal_pkg::OP_AND_OPERAND &&
        op_q != bal_pkg::OP_COMPARE_OPERAND
        |=> !flags[bal_pkg::FLG_CY];
    endproperty
    a_logic_clears_cy: assert property (p_logic_clears_cy) // RQ14
        else $error("logic op left carry set");

    property p_dad_carry;
        commit && op_q == bal_pkg::OP_DOUBLE_ADD
        |=> flags[bal_pkg::FLG_CY] == ({1'b0, $past(mem_addr)} +
            {1'b0, $past(pv_chk)} > 17'h0_FFFF) &&
            flags[7:1] == $past(flags[7:1]);
    endproperty
    a_dad_carry: assert property (p_dad_carry) // RQ10
        else $error("double add carry wrong");

    assign pv_chk = pair_value(pair_q, gpr[{pair_q, 1'b0}],
                               gpr[{pair_q, 1'b1}], sp);
endmodule

// [test/bal_host.sv]
// APB master model standing in for the decoder side
`timescale 1ns/1ns
module bal_host
(
    // Clock
    input  wire logic        pclk,
    // APB master
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [7:0]  paddr,
    output logic      [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    // Idle bus from time zero
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    // Setup, then access held until pready is seen at an edge
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic e);
    begin
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d; // Stale data must not look valid
    end
    endtask
endmodule

// [test/tb.sv]
// Self-checking bench for the byte arithmetic datapath
`timescale 1ns/1ns
module tb;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [15:0] mem_addr;
    logic [31:0] rq;
    logic        re;
    int          n_fail;
    int          check_count;
    logic [3:0]  ops [12] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h7, 4'h8,
                              4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'hE};
    bal_alu uut(.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .mem_addr(mem_addr));
    bal_host host(.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    // 10 MHz clock
    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    task automatic complete_run;
    begin
        if (n_fail == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    end
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    begin
        check_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        host.xfer(1'b1, a, v, rq, re);
    endtask
    task automatic rd(input logic [7:0] a);
        host.xfer(1'b0, a, 32'h0, rq, re);
    endtask
    // Expected state count of each operation
    function automatic logic [3:0] states(input logic [3:0] op,
        input logic [2:0] s);
        case (op)
            4'h1, 4'h9, 4'hB, 4'hD: return 4'h7;
            4'h2, 4'h3: return s == 3'h6 ? 4'hA : 4'h5;
            4'h4, 4'h5: return 4'h5;
            4'h6: return 4'hA;
            4'h7: return 4'h4;
            default: return s == 3'h6 ? 4'h7 : 4'h4;
        endcase
    endfunction
    // Command, poll until idle, then check cycle and state counts
    task automatic cmd(input logic [3:0] op, input logic [2:0] s,
        input logic [1:0] pr);
        logic [3:0] st;
    begin
        st = states(op, s);
        wr(bal_pkg::OFF_CMD, {22'h0, pr, 1'b0, s, op});
        do
            rd(bal_pkg::OFF_STATUS);
        while (rq[0] !== 1'b0);
        chk(rq[11:4], {st, st > 4'h7 ? 4'h3 : st > 4'h5 ? 4'h2 : 4'h1});
    end
    endtask
    // Expected {result, flags}; compare leaves the accumulator
    function automatic logic [15:0] model(input logic [3:0] op,
        input logic [7:0] a, input logic [7:0] b, input logic [7:0] f);
        logic [8:0] r;
        logic       ac;
        logic       cy;
        cy = op == 4'hE ? 1'b0 : f[0];
        ac = 1'b0;
        r = {1'b0, a};
        case (op)
            4'h0, 4'h1, 4'hE:
            begin
                r = {1'b0, a} - {1'b0, b} - {8'h0, cy};
                ac = ({1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, ~cy}) > 5'hF;
                cy = r[8];
            end
            4'h2:
            begin
                r = {1'b0, b} + 9'h1;
                ac = b[3:0] == 4'hF;
            end
            4'h3:
            begin
                r = {1'b0, b} - 9'h1;
                ac = b[3:0] != 4'h0;
            end
            4'h7:
            begin
                if (a[3:0] > 4'h9 || f[4])
                    r = r + 9'h6;
                ac = a[3:0] > 4'h9;
                if (r[7:4] > 4'h9 || cy || r[8])
                begin
                    cy = cy | r[8] | (r[7:4] > 4'h9);
                    r = r + 9'h60;
                end
            end
            4'h8, 4'h9:
            begin
                r = {1'b0, a & b};
                ac = op == 4'h8 && (a[3] | b[3]);
                cy = 1'b0;
            end
            default:
            begin
                r = {1'b0, op[2] ? a | b : a ^ b};
                cy = 1'b0;
            end
        endcase
        return {op == 4'hE ? a : r[7:0], r[7], r[7:0] == 8'h0, 1'b0, ac,
            1'b0, ~^r[7:0], 1'b0, cy};
    endfunction
    // Reset, refusals, pairs, then random ops
    initial
    begin
        logic [3:0]  op;
        logic [2:0]  s;
        logic [7:0]  a;
        logic [7:0]  b;
        logic [7:0]  f;
        logic [15:0] e;
        n_fail = 0;
        check_count = 0;
        presetn = 1'b0;
        void'($urandom(32'h2BC6D536));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rd(bal_pkg::OFF_GPR_LAST);
        chk(rq, 32'h0);
        rd(8'h3C);
        chk({31'h0, re}, 32'h1);
        wr(bal_pkg::OFF_CMD, 32'hF);
        chk({31'h0, re}, 32'h1);
        wr(8'h04, 32'hFF);
        wr(8'h10, 32'hFF);
        wr(8'h14, 32'hFF);
        wr(bal_pkg::OFF_FLAGS, 32'hD4);
        cmd(4'h4, 3'h0, bal_pkg::PAIR_BC);
        cmd(4'h5, 3'h0, bal_pkg::PAIR_DE);
        cmd(4'h6, 3'h0, bal_pkg::PAIR_DE);
        rd(8'h00);
        chk(rq, 32'h1);
        rd(8'h08);
        chk(rq, 32'hFF);
        chk({16'h0, mem_addr}, 32'hFFFE);
        rd(bal_pkg::OFF_FLAGS);
        chk(rq, 32'hD5);
        // First twelve walk every byte operation at boundary operands
        for (int i = 0; i < 60; i++)
        begin
            op = i < 12 ? ops[i] : ops[$urandom_range(0, 11)];
            s = $urandom_range(0, 1) ? 3'h6 : 3'h0;
            a = i < 12 ? 8'h00 : 8'($urandom);
            b = i < 12 ? (i < 6 ? 8'hFF : 8'h00) : 8'($urandom);
            f = i < 12 ? 8'h11 : 8'($urandom) & 8'hD5;
            wr(8'h00, {24'h0, b});
            wr(8'h18, {24'h0, b});
            wr(bal_pkg::OFF_IMM, {24'h0, b});
            wr(bal_pkg::OFF_GPR_LAST, {24'h0, a});
            wr(bal_pkg::OFF_FLAGS, {24'h0, f});
            cmd(op, s, 2'h0);
            e = model(op, a, b, f);
            rd(op == 4'h2 || op == 4'h3 ? {3'h0, s, 2'h0} : 8'h1C);
            chk(rq, {24'h0, e[15:8]});
            rd(bal_pkg::OFF_FLAGS);
            chk(rq, {24'h0, e[7:0]});
        end
        complete_run();
    end
    // Hang guard
    initial
    begin
        repeat (20000) @(posedge pclk);
        n_fail++;
        complete_run();
    end
endmodule
